// File: sensor_trim_pkg.sv
// Constants shared by the sensor trim configuration and lookup logic
package sensor_trim_pkg;
  // Configuration word field positions
  localparam int OSC_TRIM_HI      = 15;
  localparam int OSC_TRIM_LO      = 13;
  localparam int EXT_RES_BIT      = 12;
  localparam int CLK_OUT_BIT      = 11;
  localparam int POL_SWAP_BIT     = 10;
  localparam int COARSE_SIGN_BIT  = 9;
  localparam int COARSE_MAG_HI    = 8;
  localparam int COARSE_MAG_LO    = 6;
  localparam int GAIN_HI          = 5;
  localparam int GAIN_LO          = 2;
  localparam int DAC_SIGN_BIT     = 1;
  localparam int TEMPCO_SIGN_BIT  = 0;

  // Reset values
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] LOCK_RESET   = 16'h0000;
  localparam logic [7:0]  TEMP_RESET   = 8'h00;

  // Calibration register select codes
  localparam logic [3:0] SEL_CONFIG = 4'h0;

  // Lock pattern in the low byte
  localparam logic [7:0] LOCK_PATTERN = 8'hFF;

  // Oscillator frequency in kHz per trim code
  localparam logic [10:0] OSC_KHZ_NOMINAL = 11'h3E8;  // 1000
  localparam logic [10:0] OSC_KHZ_P1      = 11'h446;  // 1094
  localparam logic [10:0] OSC_KHZ_P2      = 11'h4A4;  // 1188
  localparam logic [10:0] OSC_KHZ_P3      = 11'h501;  // 1281
  localparam logic [10:0] OSC_KHZ_M4      = 11'h271;  // 625
  localparam logic [10:0] OSC_KHZ_M3      = 11'h2CF;  // 719
  localparam logic [10:0] OSC_KHZ_M2      = 11'h32C;  // 812
  localparam logic [10:0] OSC_KHZ_M1      = 11'h38A;  // 906

  // Gain law: base plus step per code
  localparam logic [7:0] GAIN_BASE = 8'h27;  // 39
  localparam logic [7:0] GAIN_STEP = 8'h0D;  // 13

  // Coarse offset magnitude in hundredths of a percent of supply, code 7 last
  localparam logic [6:0] COARSE_STEP_PCT = 7'h12;  // 18
  localparam logic [6:0] COARSE_TOP_PCT  = 7'h7D;  // 125

  // Lookup map
  localparam logic [7:0] TEMP_INDEX_MAX  = 8'hAF;
  localparam logic [7:0] TEMP_INDEX_UPPER = 8'h80;
  localparam logic [9:0] SPAN_BASE_LOW   = 10'h200;
  localparam logic [9:0] OFFSET_BASE_UP  = 10'h100;
  localparam logic [9:0] SPAN_BASE_UP    = 10'h1A0;
endpackage

// File: coeff_addr_map.sv
// Temperature index to EEPROM coefficient byte address mapping
`timescale 1ns/1ps
`default_nettype none
module coeff_addr_map
  import sensor_trim_pkg::*;
(
  input  wire logic [7:0] temp_index,
  output logic      [9:0] offset_addr_low,
  output logic      [9:0] span_addr_low
);
  logic [7:0] idx_sat;
  logic [9:0] idx_x2;

  // Indices past the last table entry would land outside the map
  assign idx_sat = (temp_index > TEMP_INDEX_MAX) ? TEMP_INDEX_MAX : temp_index;

  always_comb begin
    if (idx_sat < TEMP_INDEX_UPPER) begin
      idx_x2          = {1'b0, idx_sat, 1'b0};
      offset_addr_low = idx_x2;
      span_addr_low   = 10'(SPAN_BASE_LOW + idx_x2);
    end else begin
      idx_x2          = {2'b00, idx_sat[6:0], 1'b0};
      offset_addr_low = 10'(OFFSET_BASE_UP + idx_x2);
      span_addr_low   = 10'(SPAN_BASE_UP + idx_x2);
    end
  end
endmodule // coeff_addr_map
`default_nettype wire

// File: sensor_trim_config.sv
// Configuration word, lock word and coefficient lookup of the sensor conditioner
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Trim code sets oscillator frequency offset
// - Bit 12 selects external bias resistors
// - Bit 11 enables clock output driver
// - Bit 10 swaps bridge input polarity
// - Coarse offset magnitude bits 8:6, sign bit 9
// - Coarse offset 0.18 percent steps, 1.25 top
// - Gain equals 39 plus 13 per code
// - Bit 1 sets offset DAC sign
// - Bit 0 sets offset tempco DAC sign
// - Keep 8-bit temperature index, rises with heat
// - Index maps to offset and span EEPROM bytes
// - Lock low byte FF kills serial, routes output
// - Load command at select 0 copies holding register
module sensor_trim_config
  import sensor_trim_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [15:0] holding_register,
  input  wire logic [3:0]  cal_register_select,
  input  wire logic        load_cal_register_cmd,
  input  wire logic        lock_load,
  input  wire logic [7:0]  temp_sensor_code,
  output logic      [15:0] configuration_word,
  output logic      [15:0] lock_control_word,
  output logic      [2:0]  oscillator_trim,
  output logic      [10:0] osc_freq_khz,
  output logic             external_resistor_select,
  output logic             clock_output_enable,
  output logic             input_polarity_swap,
  output logic             coarse_offset_sign,
  output logic      [2:0]  coarse_offset_magnitude,
  output logic      [7:0]  coarse_offset_pct,
  output logic      [3:0]  gain_code,
  output logic      [7:0]  gain_value,
  output logic             offset_dac_sign,
  output logic             offset_tempco_dac_sign,
  output logic      [7:0]  temp_index,
  output logic      [9:0]  offset_addr_low,
  output logic      [9:0]  offset_addr_high,
  output logic      [9:0]  span_addr_low,
  output logic      [9:0]  span_addr_high,
  output logic             serial_enable,
  output logic             out_to_gain_stage
);
  logic [15:0] config_r;
  logic [15:0] lock_r;
  logic [10:0] osc_khz_r;
  logic [7:0]  coarse_pct_r;
  logic [7:0]  gain_r;
  logic [7:0]  temp_r;
  logic [9:0]  off_addr_r;
  logic [9:0]  span_addr_r;
  logic [9:0]  off_addr_nxt;
  logic [9:0]  span_addr_nxt;
  logic        locked;
  logic        cfg_load;

  function automatic logic [10:0] osc_decode(input logic [2:0] code);
    unique case (code)
      3'b000:  osc_decode = OSC_KHZ_NOMINAL;
      3'b001:  osc_decode = OSC_KHZ_P1;
      3'b010:  osc_decode = OSC_KHZ_P2;
      3'b011:  osc_decode = OSC_KHZ_P3;
      3'b100:  osc_decode = OSC_KHZ_M4;
      3'b101:  osc_decode = OSC_KHZ_M3;
      3'b110:  osc_decode = OSC_KHZ_M2;
      3'b111:  osc_decode = OSC_KHZ_M1;
    endcase
  endfunction

  // Signed hundredths of a percent; top code is 1.25, not 7 x 0.18
  function automatic logic [7:0] coarse_decode(input logic sign, input logic [2:0] mag);
    logic [6:0] pct;
    pct = (mag == 3'h7) ? COARSE_TOP_PCT : 7'(COARSE_STEP_PCT * mag);
    coarse_decode = sign ? {1'b0, pct} : 8'(-{1'b0, pct});
  endfunction

  function automatic logic [7:0] gain_decode(input logic [3:0] code);
    gain_decode = 8'(GAIN_BASE + 8'(GAIN_STEP * code));
  endfunction

  // Serial commands cannot reach a locked part
  assign locked   = (lock_r[7:0] == LOCK_PATTERN);
  assign cfg_load = load_cal_register_cmd && !locked && (cal_register_select == SEL_CONFIG);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      config_r <= CONFIG_RESET;
    end else if (cfg_load) begin
      config_r <= holding_register;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_khz_r    <= OSC_KHZ_NOMINAL;
      coarse_pct_r <= 8'h00;
      gain_r       <= GAIN_BASE;
    end else if (cfg_load) begin
      osc_khz_r    <= osc_decode(holding_register[OSC_TRIM_HI:OSC_TRIM_LO]);
      coarse_pct_r <= coarse_decode(holding_register[COARSE_SIGN_BIT],
                                    holding_register[COARSE_MAG_HI:COARSE_MAG_LO]);
      gain_r       <= gain_decode(holding_register[GAIN_HI:GAIN_LO]);
    end
  end

  // Once locked the word cannot be rewritten from the link
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_r <= LOCK_RESET;
    end else if (lock_load && !locked) begin
      lock_r <= holding_register;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      temp_r <= TEMP_RESET;
    end else begin
      temp_r <= temp_sensor_code;
    end
  end

  coeff_addr_map u_map (
    .temp_index      (temp_r),
    .offset_addr_low (off_addr_nxt),
    .span_addr_low   (span_addr_nxt)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      off_addr_r  <= 10'h000;
      span_addr_r <= SPAN_BASE_LOW;
    end else begin
      off_addr_r  <= off_addr_nxt;
      span_addr_r <= span_addr_nxt;
    end
  end

  assign configuration_word       = config_r;
  assign lock_control_word        = lock_r;
  assign oscillator_trim          = config_r[OSC_TRIM_HI:OSC_TRIM_LO];
  assign osc_freq_khz             = osc_khz_r;
  assign external_resistor_select = config_r[EXT_RES_BIT];
  assign clock_output_enable      = config_r[CLK_OUT_BIT];
  assign input_polarity_swap      = config_r[POL_SWAP_BIT];
  assign coarse_offset_sign       = config_r[COARSE_SIGN_BIT];
  assign coarse_offset_magnitude  = config_r[COARSE_MAG_HI:COARSE_MAG_LO];
  assign coarse_offset_pct        = coarse_pct_r;
  assign gain_code                = config_r[GAIN_HI:GAIN_LO];
  assign gain_value               = gain_r;
  assign offset_dac_sign          = config_r[DAC_SIGN_BIT];
  assign offset_tempco_dac_sign   = config_r[TEMPCO_SIGN_BIT];
  assign temp_index               = temp_r;
  assign offset_addr_low          = off_addr_r;
  assign offset_addr_high         = off_addr_r | 10'h001;
  assign span_addr_low            = span_addr_r;
  assign span_addr_high           = span_addr_r | 10'h001;
  assign serial_enable            = !locked;
  assign out_to_gain_stage        = locked;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_LOAD_COPIES: assert property (cfg_load |=> configuration_word == $past(holding_register))
    else $error("Configuration word not loaded from holding register");
  AST_NO_LOAD_HOLDS: assert property (!cfg_load |=> $stable(configuration_word))
    else $error("Configuration word changed without load");
  AST_LOCK_BLOCKS: assert property (locked && load_cal_register_cmd |=> $stable(configuration_word))
    else $error("Locked part accepted a load");
  AST_LOCK_OUTPUTS: assert property (serial_enable == !(lock_control_word[7:0] == 8'hFF)
                                     && out_to_gain_stage == !serial_enable)
    else $error("Lock outputs disagree with lock word");
  AST_GAIN_LAW: assert property (##1 !$past(reset) |-> gain_value == 8'(8'h27 + 8'h0D * gain_code))
    else $error("Gain value does not follow gain code");
  AST_OSC_NOMINAL: assert property (oscillator_trim == 3'b000 |-> osc_freq_khz == 11'h3E8)
    else $error("Nominal trim code not 1000 kHz");
  AST_COARSE_ZERO: assert property (coarse_offset_magnitude == 3'h0 |-> coarse_offset_pct == 8'h00)
    else $error("Zero magnitude gave nonzero offset");
  AST_COARSE_TOP: assert property (coarse_offset_magnitude == 3'h7 && coarse_offset_sign
                                   |-> coarse_offset_pct == 8'h7D)
    else $error("Top positive offset not 1.25 percent");
  AST_ADDR_SAT: assert property (temp_sensor_code > 8'hAF
                                 |-> ##2 span_addr_low == 10'h1FE && offset_addr_low == 10'h15E)
    else $error("Saturated index gave wrong address");
  AST_ADDR_LOW: assert property (temp_sensor_code < 8'h80
                                 |-> ##2 offset_addr_low == {1'b0, $past(temp_sensor_code, 2), 1'b0})
    else $error("Low index offset address wrong");

  // Decode paths checked against each other, since each could drift on its own
  AST_LOCK_TAKES: assert property (lock_load && !locked && holding_register[7:0] == 8'hFF
                                   |=> !serial_enable && out_to_gain_stage)
    else $error("Lock pattern did not disable the serial link");
  AST_LOCK_STICKS: assert property (locked |=> locked && $stable(lock_control_word))
    else $error("Lock word changed while locked");
  AST_OTHER_SELECT: assert property (cal_register_select != SEL_CONFIG |=> $stable(configuration_word))
    else $error("Load to another select changed the configuration word");
  AST_OSC_SLOW: assert property (oscillator_trim[2] |-> osc_freq_khz < 11'h3E8)
    else $error("Lower trim codes did not slow the oscillator");
  AST_OSC_FAST: assert property (!oscillator_trim[2] && oscillator_trim != 3'h0 |-> osc_freq_khz > 11'h3E8)
    else $error("Upper trim codes did not speed up the oscillator");
  AST_OSC_BOTTOM: assert property (oscillator_trim == 3'h4 |-> osc_freq_khz == 11'h271)
    else $error("Slowest trim code not 625 kHz");
  AST_COARSE_SIGN: assert property (coarse_offset_magnitude != 3'h0
                                    |-> coarse_offset_pct[7] == !coarse_offset_sign)
    else $error("Coarse offset direction does not follow sign bit");
  AST_COARSE_STEP: assert property (coarse_offset_magnitude == 3'h1 && coarse_offset_sign
                                    |-> coarse_offset_pct == 8'h12)
    else $error("First coarse step not 0.18 percent");
  AST_GAIN_TOP: assert property (gain_code == 4'hF |-> gain_value == 8'hEA)
    else $error("Top gain code not 234");
  AST_TEMP_FOLLOWS: assert property (1'b1 |=> temp_index == $past(temp_sensor_code))
    else $error("Temperature index did not follow the sensor code");
  AST_SPAN_LOW: assert property (temp_sensor_code < 8'h80
                                 |-> ##2 span_addr_low == 10'(offset_addr_low + 10'h200))
    else $error("Low index span address not offset address plus 200");
  AST_SPAN_UP: assert property (temp_sensor_code >= 8'h80 && temp_sensor_code <= 8'hAF
                                |-> ##2 span_addr_low == 10'(offset_addr_low + 10'h0A0))
    else $error("Upper index span address not offset address plus A0");

  COV_LOAD: cover property (cfg_load);
  COV_LOCK: cover property (lock_load ##1 locked);
  COV_UPPER: cover property (temp_index >= 8'h80 && temp_index <= 8'hAF);
  COV_SATURATE: cover property (temp_index > 8'hAF);
  COV_REFUSED: cover property (locked && load_cal_register_cmd);
endmodule // sensor_trim_config
`default_nettype wire

// File: cal_host_model.sv
// Calibration host model that loads configuration and lock words
`timescale 1ns/1ps
`default_nettype none
module cal_host_model
  import sensor_trim_pkg::*;
#(
  parameter logic [2:0] FACTORY_TRIM = 3'h5
)(
  input  wire logic        clk,
  output logic      [15:0] holding_register,
  output logic      [3:0]  cal_register_select,
  output logic             load_cal_register_cmd,
  output logic             lock_load
);
  initial begin
    holding_register      = 16'h0000;
    cal_register_select   = 4'hF;
    load_cal_register_cmd = 1'b0;
    lock_load             = 1'b0;
  end
  // One load; keep merges the factory trim, cleared for the trim sweep and for other-select and lock loads
  task automatic send(input logic [15:0] v, input logic [3:0] sel, input logic keep, input logic lock);
    @(negedge clk);
    holding_register = keep ? {FACTORY_TRIM, v[12:0]} : v;
    cal_register_select = sel;
    load_cal_register_cmd = !lock;
    lock_load = lock;
    @(negedge clk);
    load_cal_register_cmd = 1'b0;
    lock_load = 1'b0;
    // Released lines never keep the last value, so a late sample shows up
    holding_register = ~holding_register;
    cal_register_select = ~sel;
  endtask
endmodule // cal_host_model
`default_nettype wire

// File: sensor_trim_config_and_lookup_bench.sv
// Self-checking bench for the sensor trim configuration and lookup logic
`timescale 1ns/1ps
`default_nettype none
module sensor_trim_config_and_lookup_bench
  import sensor_trim_pkg::*;
;
  localparam logic [2:0] TRIM = 3'h5; // Arbitrary factory trim
  logic        clk, reset, load_cal_register_cmd, lock_load, external_resistor_select, clock_output_enable;
  logic        input_polarity_swap, coarse_offset_sign, offset_dac_sign, offset_tempco_dac_sign;
  logic        serial_enable, out_to_gain_stage;
  logic [2:0]  oscillator_trim, coarse_offset_magnitude;
  logic [3:0]  cal_register_select, gain_code;
  logic [7:0]  temp_sensor_code, temp_index, coarse_offset_pct, gain_value, t;
  logic [9:0]  offset_addr_low, offset_addr_high, span_addr_low, span_addr_high;
  logic [10:0] osc_freq_khz;
  logic [15:0] holding_register, configuration_word, lock_control_word, w, e;
  logic [10:0] khz [8] = '{11'h3E8, 11'h446, 11'h4A4, 11'h501, 11'h271, 11'h2CF, 11'h32C, 11'h38A};
  logic [7:0]  corner [7] = '{8'h00, 8'h41, 8'h7F, 8'h80, 8'hAF, 8'hB0, 8'hFF};
  int          num_errors = 0, comparisons = 0, cycles = 0;

  sensor_trim_config sensor_trim_config_inst (.clk(clk), .reset(reset), .holding_register(holding_register),
    .cal_register_select(cal_register_select), .load_cal_register_cmd(load_cal_register_cmd),
    .lock_load(lock_load), .temp_sensor_code(temp_sensor_code), .configuration_word(configuration_word),
    .lock_control_word(lock_control_word), .oscillator_trim(oscillator_trim), .osc_freq_khz(osc_freq_khz),
    .external_resistor_select(external_resistor_select), .clock_output_enable(clock_output_enable),
    .input_polarity_swap(input_polarity_swap), .coarse_offset_sign(coarse_offset_sign),
    .coarse_offset_magnitude(coarse_offset_magnitude), .coarse_offset_pct(coarse_offset_pct),
    .gain_code(gain_code), .gain_value(gain_value), .offset_dac_sign(offset_dac_sign),
    .offset_tempco_dac_sign(offset_tempco_dac_sign), .temp_index(temp_index),
    .offset_addr_low(offset_addr_low), .offset_addr_high(offset_addr_high), .span_addr_low(span_addr_low),
    .span_addr_high(span_addr_high), .serial_enable(serial_enable), .out_to_gain_stage(out_to_gain_stage));
  cal_host_model #(.FACTORY_TRIM(TRIM)) cal_host_model_inst (.clk(clk), .holding_register(holding_register),
    .cal_register_select(cal_register_select), .load_cal_register_cmd(load_cal_register_cmd), .lock_load(lock_load));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // The whole run needs well under 400 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] pct(input logic [3:0] c);
    pct = (c[2:0] == 3'h7) ? 8'h7D : 8'h12 * c[2:0];
    return c[3] ? pct : -pct;
  endfunction
  task automatic cfg(input logic [15:0] v, input logic keep);
    cal_host_model_inst.send(v, 4'h0, keep, 1'b0);
    e = keep ? {TRIM, v[12:0]} : v;
    check(configuration_word, e);
    check({oscillator_trim, external_resistor_select, clock_output_enable, input_polarity_swap, coarse_offset_sign,
      coarse_offset_magnitude, gain_code, offset_dac_sign, offset_tempco_dac_sign}, e);
    check(16'(osc_freq_khz), 16'(khz[e[15:13]]));
    check(16'(coarse_offset_pct), 16'(pct(e[9:6])));
    check(16'(gain_value), 16'(8'h27 + 8'h0D * e[5:2]));
  endtask
  task automatic temp(input logic [7:0] v);
    @(negedge clk);
    temp_sensor_code = v;
    repeat (2) @(negedge clk);
    t = (v > 8'hAF) ? 8'hAF : v;
    w = (t < 8'h80) ? {7'h0, t, 1'b0} : 16'h100 + {7'h0, t - 8'h80, 1'b0};
    check(16'(temp_index), 16'(v));
    check(16'(offset_addr_low), w);
    check(16'(offset_addr_high), w + 16'h1);
    w = (t < 8'h80) ? w + 16'h200 : w + 16'hA0;
    check(16'(span_addr_low), w);
    check(16'(span_addr_high), w + 16'h1);
  endtask

  initial begin
    reset = 1'b1;
    temp_sensor_code = 8'h00;
    void'($urandom(61));
    repeat (16) @(negedge clk);
    check(configuration_word, CONFIG_RESET);
    reset = 1'b0;
    for (int i = 0; i < 8; i++) cfg({i[2:0], 13'($urandom)}, 1'b0);
    for (int i = 0; i < 16; i++) cfg({6'($urandom), i[3:0], i[3:0], 2'($urandom)}, 1'b1);
    for (int i = 0; i < 20; i++) cfg(16'($urandom), 1'b1);
    // Other selects must leave the word alone
    for (int i = 1; i < 16; i++) begin
      cal_host_model_inst.send(~e, i[3:0], 1'b0, 1'b0);
      check(configuration_word, e);
    end
    foreach (corner[k]) temp(corner[k]);
    repeat (20) temp(8'($urandom));
    cal_host_model_inst.send(16'hFF00, 4'h0, 1'b0, 1'b1);
    check({14'h0, serial_enable, out_to_gain_stage}, 16'h2);
    cal_host_model_inst.send(16'h12FF, 4'h0, 1'b0, 1'b1);
    check(lock_control_word, 16'h12FF);
    check({14'h0, serial_enable, out_to_gain_stage}, 16'h1);
    cal_host_model_inst.send(~e, 4'h0, 1'b0, 1'b0);
    check(configuration_word, e);
    cal_host_model_inst.send(16'h0000, 4'h0, 1'b0, 1'b1);
    check(lock_control_word, 16'h12FF);
    reset = 1'b1;
    @(negedge clk);
    reset = 1'b0;
    check({14'h0, serial_enable, out_to_gain_stage}, 16'h2);
    check(configuration_word, CONFIG_RESET);
    check(lock_control_word, LOCK_RESET);
    test_done();
  end
endmodule // sensor_trim_config_and_lookup_bench
`default_nettype wire
